// ---- dv/test_uart_block_read_responder.sv ----
// test_uart_block_read_responder: self-checking bench for the block read responder
// assumes the host model on the byte side and a shortened byte gap limit
`timescale 1ns/1ns
module test_uart_block_read_responder;
	localparam int GAP = 200; // keeps the gap scenario short
	logic [7:0]   RX_BYTE, TX_BYTE;
	logic         MCLK, RSTN, RX_VALID, RX_PARITY_ERR, TX_VALID, TX_READY;
	logic         SINGLE_PHASE_MODE, SINGLE_MEAS_START, LINK_ERR, LINK_ERR_CLR, BUSY;
	logic [799:0] MEAS_WORDS;
	int           n_mismatch = 0;
	int           tests_run = 0;
	int           n_meas = 0;

	ubr_responder #(.GAP_CYCLES(GAP)) u_dut (.MCLK(MCLK), .RSTN(RSTN), .RX_BYTE(RX_BYTE), .RX_VALID(RX_VALID),
		.RX_PARITY_ERR(RX_PARITY_ERR), .TX_BYTE(TX_BYTE), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
		.MEAS_WORDS(MEAS_WORDS), .SINGLE_PHASE_MODE(SINGLE_PHASE_MODE), .SINGLE_MEAS_START(SINGLE_MEAS_START),
		.LINK_ERR(LINK_ERR), .LINK_ERR_CLR(LINK_ERR_CLR), .BUSY(BUSY));
	ubr_host_model u_host (.MCLK(MCLK), .RX_BYTE(RX_BYTE), .RX_VALID(RX_VALID), .RX_PARITY_ERR(RX_PARITY_ERR),
		.TX_BYTE(TX_BYTE), .TX_VALID(TX_VALID), .TX_READY(TX_READY));

	// distinct bytes per item so a swapped item or byte order shows
	function automatic logic [31:0] item_word(input int k);
		item_word = {8'(k) | 8'h80, 8'(k) | 8'h40, 8'(k) | 8'h20, 8'(k)};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one command frame, then wait out any reply under a bound
	task automatic frame(input logic [7:0] hdr, op, m, dck, input int perr, gap, input logic rep);
		logic [7:0] b[4];
		int         i;
		b = '{hdr, op, m, 8'(8'h33 + ~8'(op + m) + dck)};
		u_host.got.delete();
		n_meas = 0;
		for (i = 0; i < 4; i++)
			u_host.send(b[i], 1'(i == perr), (i == 1) ? gap : 0);
		repeat (2) @(posedge MCLK);
		#2;
		check(32'(BUSY), 32'(rep));
		i = 0;
		while ((BUSY !== 1'b0 || TX_VALID !== 1'b0) && i < 5000) begin
			@(posedge MCLK);
			#2;
			i++;
		end
		if (i == 5000)
			check(32'h1, 32'h0);
	endtask

	// read from start m; every byte, the sum and the trigger pulse checked
	task automatic s_read(input int m, slow, input logic mode, input int gap);
		logic [7:0] sum, x;
		int         k, j, n;
		u_host.slow = slow;
		SINGLE_PHASE_MODE = mode;
		frame(8'h7d, 8'h03, 8'(m), 8'h00, -1, gap, 1'b1);
		sum = 8'(8'h03 + m);
		n = 0;
		for (k = m; k <= 24; k++) begin
			for (j = 0; j < 4; j++) begin
				x = 8'(item_word(k) >> (8 * j));
				check(32'(u_host.got[n]), 32'(x));
				sum += x;
				n++;
			end
		end
		check(32'(u_host.got[n]), 32'(8'(8'h33 + ~sum)));
		check(u_host.got.size(), n + 1);
		check(n_meas, 32'(mode));
		check(32'(LINK_ERR), 32'h0);
	endtask

	// refused frame: no reply, error flag as expected, then flag cleared
	task automatic s_bad(input logic [7:0] hdr, op, m, dck, input int perr, gap, input logic err);
		frame(hdr, op, m, dck, perr, gap, 1'b0);
		check(u_host.got.size(), 0);
		check(32'(LINK_ERR), 32'(err));
		LINK_ERR_CLR = 1'b1;
		@(posedge MCLK);
		#2;
		LINK_ERR_CLR = 1'b0;
		@(posedge MCLK);
		#2;
		check(32'(LINK_ERR), 32'h0);
	endtask

	initial begin
		MCLK = 1'b0;
		forever #10 MCLK = ~MCLK;
	end

	// count measurement trigger pulses seen at each edge
	always @(posedge MCLK) begin
		if (SINGLE_MEAS_START === 1'b1)
			n_meas++;
	end

	// watchdog well past the thousand or so cycles the run needs
	initial begin
		#200000;
		check(32'h1, 32'h0);
		conclude();
	end

	initial begin
		RSTN = 1'b0;
		LINK_ERR_CLR = 1'b0;
		SINGLE_PHASE_MODE = 1'b0;
		for (int k = 0; k < 25; k++)
			MEAS_WORDS[32*k +: 32] = item_word(k);
		repeat (8) @(posedge MCLK);
		#2;
		RSTN = 1'b1;
		s_read(0, 1, 1'b1, 0);
		s_read(3, 0, 1'b0, 0);
		s_read(15, 1, 1'b1, GAP - 20);
		s_bad(8'h7c, 8'h03, 8'h03, 8'h00, -1, 0, 1'b0);
		s_bad(8'h7d, 8'h03, 8'h03, 8'h00, 2, 0, 1'b1);
		s_bad(8'h7d, 8'h03, 8'h03, 8'h01, -1, 0, 1'b1);
		s_bad(8'h7d, 8'h02, 8'h03, 8'h00, -1, 0, 1'b0);
		s_bad(8'h7d, 8'h03, 8'h03, 8'h00, -1, GAP + 20, 1'b1);
		s_bad(8'h7d, 8'h03, 8'h43, 8'h00, -1, 0, 1'b0);
		s_read(7, 0, 1'b0, 0);
		s_read(24, 1, 1'b1, 0);
		conclude();
	end
endmodule

// ---- dv/ubr_host_model.sv ----
// ubr_host_model: host side of the command link, byte level
// assumes the bench calls send for every command byte; reply bytes gather in got
`timescale 1ns/1ns
module ubr_host_model (
	input  wire logic       MCLK,
	output logic [7:0]      RX_BYTE,
	output logic            RX_VALID,
	output logic            RX_PARITY_ERR,
	input  wire logic [7:0] TX_BYTE,
	input  wire logic       TX_VALID,
	output logic            TX_READY
);
	logic [7:0] got[$];
	int         slow = 0;

	initial begin
		RX_BYTE = 8'h00;
		RX_VALID = 1'b0;
		RX_PARITY_ERR = 1'b0;
		TX_READY = 1'b0;
	end

	// one byte pulse; idle line shows the inverse so stale data never matches
	task automatic send(input logic [7:0] b, input logic perr, input int gap);
		@(posedge MCLK);
		#2;
		RX_BYTE = b;
		RX_VALID = 1'b1;
		RX_PARITY_ERR = perr;
		@(posedge MCLK);
		#2;
		RX_VALID = 1'b0;
		RX_PARITY_ERR = 1'b0;
		RX_BYTE = ~b;
		repeat (gap) @(posedge MCLK); // caller keeps this under the limit except in the gap-error case
	endtask

	// take reply bytes in arrival order; slow mode stalls every other cycle
	always @(posedge MCLK) begin
		if (TX_VALID === 1'b1 && TX_READY === 1'b1)
			got.push_back(TX_BYTE);
		#2;
		TX_READY = (slow != 0) ? ~TX_READY : 1'b1;
	end
endmodule

// ---- logic/ubr_byte_if.sv ----
// ubr_byte_if: item number and word between the responder and its item selector
// assumes one clock domain; item number out, 32-bit word back in the same cycle
`timescale 1ns/1ns
interface ubr_byte_if;
	logic [4:0]  item;
	logic [31:0] word;
	modport ctl (output item, input word);
	modport sel (input item, output word);
endinterface

// ---- logic/ubr_gap_timer.sv ----
// ubr_gap_timer: counts cycles since the last received byte
// assumes restart is a one-cycle pulse from the same clock
`timescale 1ns/1ns
module ubr_gap_timer #(
	parameter int GAP_CYCLES = ubr_pkg::GAP_CYCLES
) (
	input  wire logic MCLK,
	input  wire logic RSTN,
	input  wire logic run,
	input  wire logic restart,
	output logic      expired
);
	typedef struct packed {
		logic [23:0] cnt;
		logic        expired;
	} ubr_gap_s;
	ubr_gap_s st;
	ubr_gap_s next_st;

	// expiry is one pulse once the gap exceeds the limit
	always_comb begin
		next_st = st;
		next_st.expired = 1'b0;
		if (!run || restart) begin
			next_st.cnt = '0;
		end else if (st.cnt == 24'(GAP_CYCLES)) begin
			next_st.expired = 1'b1; // [RULE_16]
			next_st.cnt = '0;
		end else begin
			next_st.cnt = 24'(st.cnt + 24'h1);
		end
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign expired = st.expired;
endmodule

// ---- logic/ubr_item_mux.sv ----
// ubr_item_mux: maps a fixed-list item number to its 32-bit source
// assumes the measurement words arrive flattened, item 0 in the low bits
`timescale 1ns/1ns
module ubr_item_mux (
	input  wire logic [32*ubr_pkg::ITEM_COUNT-1:0] meas_words,
	ubr_byte_if.sel                                bus
);
	// items 0..24 in fixed order; items past 24 clamp to the last
	always_comb begin
		if (bus.item > ubr_pkg::LAST_ITEM) begin
			bus.word = meas_words[32*ubr_pkg::LAST_ITEM +: 32];
		end else begin
			bus.word = meas_words[32*bus.item +: 32]; // [RULE_07] [RULE_08] [RULE_09] [RULE_10] [RULE_11] [RULE_12]
		end
	end
endmodule

// ---- logic/ubr_pkg.sv ----
// ubr_pkg: constants and types for the block read responder
// assumes a 50 MHz system clock and a byte-level uart below this block
package ubr_pkg;
	localparam logic [7:0] HEADER_BYTE    = 8'h7d; // 0111_1101
	localparam logic [7:0] OPCODE_BLOCK   = 8'h03; // fixed-list block read
	localparam logic [7:0] FRAME_CHECKSUM_CONST    = 8'h33;
	localparam logic [7:0] START_HI_MASK  = 8'he0; // bits 7:5 zero; start numbers reach 24 and beyond
	localparam logic [4:0] LAST_ITEM      = 5'h18; // item 24
	localparam int         ITEM_COUNT     = 25;
	localparam int         CLK_HZ         = 50000000;
	localparam int         GAP_MS         = 20;
	localparam int         GAP_CYCLES     = (CLK_HZ / 1000) * GAP_MS;

	// frame position, receive states then reply states
	typedef enum logic [2:0] {
		UBR_IDLE    = 3'b000,
		UBR_OPCODE  = 3'b001,
		UBR_START   = 3'b010,
		UBR_FRAME_CHECKSUM   = 3'b011,
		UBR_REPLY   = 3'b100,
		UBR_SUMOUT  = 3'b101
	} ubr_state_e;

	// checksum helper: 0x33 plus inverse of the running sum, mod 256
	function automatic logic [7:0] ubr_frame_checksum(input logic [7:0] sum);
		ubr_frame_checksum = 8'(FRAME_CHECKSUM_CONST + ~sum);
	endfunction
endpackage

// ---- logic/ubr_responder.sv ----
// ubr_responder: serves the fixed-list block read command frame
// assumes a byte uart below: RX bytes with parity flag, TX bytes with ready
// Function
// (RULE_01) frame starts header 0x7d, opcode 0x03
// (RULE_02) third byte start number, upper bits zero
// (RULE_03) command checksum 0x33 plus inverted sum
// (RULE_04) items sent four bytes, LSB first, ascending
// (RULE_05) reply checksum covers data, opcode, start
// (RULE_06) start 24 or more: one item only
// (RULE_07) items 0-8: active, reactive, apparent power
// (RULE_08) items 9-14: RMS voltages then currents
// (RULE_09) items 15-17: phase frequencies
// (RULE_10) items 18-22: voltage and current angles
// (RULE_11) item 23: chip status word
// (RULE_12) item 24: baud measure count
// (RULE_13) below 24: send start through item 24
// (RULE_14) checksum arithmetic modulo 256
// (RULE_15) single-phase mode: reply end triggers measurement
// (RULE_16) byte gap over 20 ms aborts, flags error
// (RULE_17) parity or checksum fault aborts, flags error
// (RULE_18) header fault aborts without error flag
`timescale 1ns/1ns
module ubr_responder #(
	parameter int GAP_CYCLES = ubr_pkg::GAP_CYCLES
) (
	input  wire logic                              MCLK,
	input  wire logic                              RSTN,
	input  wire logic [7:0]                        RX_BYTE,
	input  wire logic                              RX_VALID,
	input  wire logic                              RX_PARITY_ERR,
	output logic [7:0]                             TX_BYTE,
	output logic                                   TX_VALID,
	input  wire logic                              TX_READY,
	input  wire logic [32*ubr_pkg::ITEM_COUNT-1:0] MEAS_WORDS,
	input  wire logic                              SINGLE_PHASE_MODE,
	output logic                                   SINGLE_MEAS_START,
	output logic                                   LINK_ERR,
	input  wire logic                              LINK_ERR_CLR,
	output logic                                   BUSY
);
	typedef struct packed {
		ubr_pkg::ubr_state_e state;
		logic [7:0]          opcode_byte;
		logic [7:0]          start_number_byte;
		logic [7:0]          sum;
		logic [4:0]          item;
		logic [1:0]          lane;
		logic [7:0]          tx_byte;
		logic                tx_valid;
		logic                single_meas;
		logic                link_err;
		logic                busy;
	} ubr_state_s;
	ubr_state_s st;
	ubr_state_s next_st;

	ubr_byte_if sel_bus ();
	logic       gap_expired;
	logic       receiving;
	logic [7:0] cur_byte;

	ubr_item_mux u_mux (
		.meas_words (MEAS_WORDS),
		.bus        (sel_bus)
	);

	// timer only runs mid-frame, so an idle line never raises an error
	assign receiving = (st.state == ubr_pkg::UBR_OPCODE) || (st.state == ubr_pkg::UBR_START)
	                   || (st.state == ubr_pkg::UBR_FRAME_CHECKSUM);
	ubr_gap_timer #(.GAP_CYCLES(GAP_CYCLES)) u_gap (
		.MCLK    (MCLK),
		.RSTN    (RSTN),
		.run     (receiving),
		.restart (RX_VALID),
		.expired (gap_expired)
	);

	assign sel_bus.item = st.item;
	// byte lane of the current item, least significant first
	assign cur_byte = sel_bus.word[8*st.lane +: 8]; // [RULE_04]

	// frame sequencing and reply generation
	always_comb begin
		next_st = st;
		next_st.single_meas = 1'b0;
		if (LINK_ERR_CLR) begin
			next_st.link_err = 1'b0;
		end
		case (st.state)
			ubr_pkg::UBR_IDLE: begin
				// non-header bytes are dropped silently unless they carry a parity error
				if (RX_VALID && !RX_PARITY_ERR && RX_BYTE == ubr_pkg::HEADER_BYTE) begin
					next_st.state = ubr_pkg::UBR_OPCODE; // [RULE_01] [RULE_18]
				end else if (RX_VALID && RX_PARITY_ERR) begin
					next_st.link_err = 1'b1; // [RULE_17]
				end
			end
			ubr_pkg::UBR_OPCODE: begin
				if (gap_expired) begin
					next_st.state = ubr_pkg::UBR_IDLE;
					next_st.link_err = 1'b1; // [RULE_16]
				end else if (RX_VALID && RX_PARITY_ERR) begin
					next_st.state = ubr_pkg::UBR_IDLE;
					next_st.link_err = 1'b1; // [RULE_17]
				end else if (RX_VALID && RX_BYTE == ubr_pkg::OPCODE_BLOCK) begin
					next_st.opcode_byte = RX_BYTE; // [RULE_01]
					next_st.state = ubr_pkg::UBR_START;
				end else if (RX_VALID) begin
					// other opcodes belong to other handlers; quit quietly
					next_st.state = ubr_pkg::UBR_IDLE;
				end
			end
			ubr_pkg::UBR_START: begin
				if (gap_expired) begin
					next_st.state = ubr_pkg::UBR_IDLE;
					next_st.link_err = 1'b1; // [RULE_16]
				end else if (RX_VALID && RX_PARITY_ERR) begin
					next_st.state = ubr_pkg::UBR_IDLE;
					next_st.link_err = 1'b1; // [RULE_17]
				end else if (RX_VALID) begin
					next_st.start_number_byte = RX_BYTE; // [RULE_02]
					next_st.state = ubr_pkg::UBR_FRAME_CHECKSUM;
				end
			end
			ubr_pkg::UBR_FRAME_CHECKSUM: begin
				if (gap_expired) begin
					next_st.state = ubr_pkg::UBR_IDLE;
					next_st.link_err = 1'b1; // [RULE_16]
				end else if (RX_VALID && (RX_PARITY_ERR
				         || RX_BYTE != ubr_pkg::ubr_frame_checksum(8'(st.opcode_byte + st.start_number_byte)))) begin
					next_st.state = ubr_pkg::UBR_IDLE;
					next_st.link_err = 1'b1; // [RULE_03] [RULE_17]
				end else if (RX_VALID && (st.start_number_byte & ubr_pkg::START_HI_MASK) != 8'h00) begin
					// nonzero upper bits are malformed; drop without reply
					next_st.state = ubr_pkg::UBR_IDLE; // [RULE_02]
				end else if (RX_VALID) begin
					next_st.sum = 8'(st.opcode_byte + st.start_number_byte); // [RULE_14]
					next_st.item = (st.start_number_byte[4:0] > ubr_pkg::LAST_ITEM)
					               ? ubr_pkg::LAST_ITEM : st.start_number_byte[4:0]; // [RULE_06]
					next_st.lane = 2'h0;
					next_st.state = ubr_pkg::UBR_REPLY;
				end
			end
			ubr_pkg::UBR_REPLY: begin
				// load a byte whenever the output slot is empty or consumed
				if (!st.tx_valid || TX_READY) begin
					next_st.tx_byte = cur_byte;
					next_st.tx_valid = 1'b1;
					next_st.sum = 8'(st.sum + cur_byte); // [RULE_05] [RULE_14]
					next_st.lane = 2'(st.lane + 2'h1);
					if (st.lane == 2'h3) begin
						if (st.item == ubr_pkg::LAST_ITEM) begin
							next_st.state = ubr_pkg::UBR_SUMOUT; // [RULE_13] [RULE_06]
						end else begin
							next_st.item = 5'(st.item + 5'h1); // [RULE_04] [RULE_13]
						end
					end
				end
			end
			ubr_pkg::UBR_SUMOUT: begin
				if (TX_READY) begin
					next_st.tx_byte = ubr_pkg::ubr_frame_checksum(st.sum); // [RULE_05]
					next_st.state = ubr_pkg::UBR_IDLE;
					next_st.single_meas = SINGLE_PHASE_MODE; // [RULE_15]
				end
			end
			default: begin
				next_st.state = ubr_pkg::UBR_IDLE;
			end
		endcase
		// the checksum byte may still wait while the next frame arrives;
		// drop valid once it is consumed, whatever the receive state
		if (st.state != ubr_pkg::UBR_REPLY && st.state != ubr_pkg::UBR_SUMOUT && st.tx_valid && TX_READY) begin
			next_st.tx_valid = 1'b0;
		end
		// busy is registered so the pin comes straight from a flop
		next_st.busy = (next_st.state != ubr_pkg::UBR_IDLE) || next_st.tx_valid;
	end

	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign TX_BYTE = st.tx_byte;
	assign TX_VALID = st.tx_valid;
	assign SINGLE_MEAS_START = st.single_meas;
	assign LINK_ERR = st.link_err;
	assign BUSY = st.busy;

	// a header accepted in idle moves straight to opcode wait
	property p_header_accept;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_IDLE && RX_VALID && !RX_PARITY_ERR && RX_BYTE == 8'h7d)
		|=> (st.state == ubr_pkg::UBR_OPCODE);
	endproperty
	a_header_accept: assert property (p_header_accept) else $error("header not accepted"); // [RULE_01]

	property p_bad_header_quiet;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_IDLE && RX_VALID && !RX_PARITY_ERR && RX_BYTE != 8'h7d && !LINK_ERR)
		|=> !LINK_ERR;
	endproperty
	a_bad_header_quiet: assert property (p_bad_header_quiet) else $error("header fault set error"); // [RULE_18]

	property p_parity_err;
		@(posedge MCLK) disable iff (!RSTN)
		(RX_VALID && RX_PARITY_ERR && receiving) |=> (LINK_ERR && st.state == ubr_pkg::UBR_IDLE);
	endproperty
	a_parity_err: assert property (p_parity_err) else $error("parity fault not flagged"); // [RULE_17]

	property p_frame_checksum_err;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_FRAME_CHECKSUM && RX_VALID && !gap_expired
		 && RX_BYTE != 8'(8'h33 + ~8'(st.opcode_byte + st.start_number_byte))) |=> LINK_ERR;
	endproperty
	a_frame_checksum_err: assert property (p_frame_checksum_err) else $error("checksum fault not flagged"); // [RULE_03]

	property p_gap_err;
		@(posedge MCLK) disable iff (!RSTN)
		(receiving && gap_expired) |=> (LINK_ERR && st.state == ubr_pkg::UBR_IDLE);
	endproperty
	a_gap_err: assert property (p_gap_err) else $error("gap timeout not flagged"); // [RULE_16]

	property p_reply_start;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_REPLY && st.lane == 2'h0 && !st.tx_valid)
		|=> (TX_VALID && TX_BYTE == $past(sel_bus.word[7:0]));
	endproperty
	a_reply_start: assert property (p_reply_start) else $error("first reply byte not item low byte"); // [RULE_04]

	property p_item_cap;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_REPLY) |-> (st.item <= 5'h18);
	endproperty
	a_item_cap: assert property (p_item_cap) else $error("item beyond last"); // [RULE_06]

	property p_last_to_sum;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_REPLY && st.item == 5'h18 && st.lane == 2'h3 && (!st.tx_valid || TX_READY))
		|=> (st.state == ubr_pkg::UBR_SUMOUT);
	endproperty
	a_last_to_sum: assert property (p_last_to_sum) else $error("reply did not end at item 24"); // [RULE_13]

	property p_single_meas;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_SUMOUT && TX_READY && SINGLE_PHASE_MODE) |=> SINGLE_MEAS_START ##1 !SINGLE_MEAS_START;
	endproperty
	a_single_meas: assert property (p_single_meas) else $error("single-phase trigger missing"); // [RULE_15]

	// three-phase mode must never fire the measurement trigger
	property p_no_meas;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_SUMOUT && TX_READY && !SINGLE_PHASE_MODE) |=> !SINGLE_MEAS_START;
	endproperty
	a_no_meas: assert property (p_no_meas) else $error("trigger in three-phase mode"); // [RULE_15]

	// a wrong opcode abandons the frame without raising the flag
	property p_opcode_reject;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_OPCODE && RX_VALID && !RX_PARITY_ERR && !gap_expired
		 && RX_BYTE != 8'h03 && !LINK_ERR)
		|=> (st.state == ubr_pkg::UBR_IDLE && !LINK_ERR);
	endproperty
	a_opcode_reject: assert property (p_opcode_reject) else $error("wrong opcode not dropped"); // [RULE_01]

	// the start byte is kept as received
	property p_start_capture;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_START && RX_VALID && !RX_PARITY_ERR && !gap_expired)
		|=> (st.state == ubr_pkg::UBR_FRAME_CHECKSUM && st.start_number_byte == $past(RX_BYTE));
	endproperty
	a_start_capture: assert property (p_start_capture) else $error("start number not captured"); // [RULE_02]

	// nonzero upper start bits give no reply
	property p_upper_drop;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_FRAME_CHECKSUM && RX_VALID && !RX_PARITY_ERR && !gap_expired
		 && RX_BYTE == 8'(8'h33 + ~8'(st.opcode_byte + st.start_number_byte))
		 && st.start_number_byte[7:5] != 3'h0)
		|=> (st.state == ubr_pkg::UBR_IDLE);
	endproperty
	a_upper_drop: assert property (p_upper_drop) else $error("malformed start answered"); // [RULE_02]

	// a good frame starts the reply at the requested item
	property p_first_item;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_FRAME_CHECKSUM && RX_VALID && !RX_PARITY_ERR && !gap_expired
		 && RX_BYTE == 8'(8'h33 + ~8'(st.opcode_byte + st.start_number_byte))
		 && st.start_number_byte[7:5] == 3'h0 && st.start_number_byte[4:0] < 5'h18)
		|=> (st.state == ubr_pkg::UBR_REPLY && st.item == $past(st.start_number_byte[4:0]) && st.lane == 2'h0);
	endproperty
	a_first_item: assert property (p_first_item) else $error("reply not at start item"); // [RULE_13]

	// start 24 or more answers with item 24 alone
	property p_short_reply;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_FRAME_CHECKSUM && RX_VALID && !RX_PARITY_ERR && !gap_expired
		 && RX_BYTE == 8'(8'h33 + ~8'(st.opcode_byte + st.start_number_byte))
		 && st.start_number_byte[7:5] == 3'h0 && st.start_number_byte[4:0] >= 5'h18)
		|=> (st.state == ubr_pkg::UBR_REPLY && st.item == 5'h18 && st.lane == 2'h0);
	endproperty
	a_short_reply: assert property (p_short_reply) else $error("short reply not at item 24"); // [RULE_06]

	// each loaded byte is the current lane, lanes step upward
	property p_lane_step;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_REPLY && (!st.tx_valid || TX_READY))
		|=> (TX_VALID && TX_BYTE == $past(cur_byte) && st.lane == 2'($past(st.lane) + 2'h1));
	endproperty
	a_lane_step: assert property (p_lane_step) else $error("reply byte order broken"); // [RULE_04]

	// closing byte is the constant plus the inverted running sum
	property p_sum_byte;
		@(posedge MCLK) disable iff (!RSTN)
		(st.state == ubr_pkg::UBR_SUMOUT && TX_READY)
		|=> (TX_VALID && TX_BYTE == 8'(8'h33 + ~$past(st.sum)));
	endproperty
	a_sum_byte: assert property (p_sum_byte) else $error("reply checksum wrong"); // [RULE_05]

	// a byte not yet taken stays on the output unchanged
	property p_tx_hold;
		@(posedge MCLK) disable iff (!RSTN)
		(TX_VALID && !TX_READY) |=> (TX_VALID && $stable(TX_BYTE));
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("reply byte lost before taken"); // [RULE_04]

	// with no competing set, a clear drops the flag
	property p_err_clear;
		@(posedge MCLK) disable iff (!RSTN)
		(LINK_ERR_CLR && st.state == ubr_pkg::UBR_IDLE && !RX_VALID) |=> !LINK_ERR;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("error flag not cleared"); // [RULE_17]
endmodule
